// File: core/flash_host_pkg.sv
// constants shared by the parallel flash host controller and its bus cycle engine
// assumes a 100 MHz system clock and a word-mode (x16) flash on the pins
package flash_host_pkg;

	// clock and pin timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int T_SETUP_NS     = 20;
	localparam int T_WE_PULSE_NS  = 50;
	localparam int T_READ_NS      = 120;
	localparam int T_RECOVER_NS   = 30;
	// least times round up to whole cycles
	localparam logic [3:0] SETUP_CYC   = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WE_CYC      = 4'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] READ_CYC    = 4'((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] RECOVER_CYC = 4'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;

	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA  = 8'h10;

	// control fields
	localparam int CTRL_CMD_LSB  = 0;
	localparam int CTRL_GO_BIT   = 8;
	localparam int CTRL_HV_BIT   = 16;
	localparam int CTRL_PSEL_BIT = 17;

	// status fields
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_DONE_BIT    = 1;
	localparam int ST_OK_BIT      = 2;
	localparam int ST_FAIL_BIT    = 3;
	localparam int ST_REFUSED_BIT = 4;

	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST  = 18'h0_0000;
	localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
	localparam logic [31:0]       WORD_ZERO = 32'h0000_0000;

	// command field encodings
	localparam logic [2:0] CMD_READ       = 3'h0;
	localparam logic [2:0] CMD_WRITE      = 3'h1;
	localparam logic [2:0] CMD_RESET      = 3'h2;
	localparam logic [2:0] CMD_ID         = 3'h3;
	localparam logic [2:0] CMD_CHIP_ERASE = 3'h4;
	localparam logic [2:0] CMD_PROTECT    = 3'h5;

	// flash bus codes and unlock addresses (word mode)
	localparam logic [DATA_W-1:0] RESET_CODE   = 16'h00F0;
	localparam logic [DATA_W-1:0] UNLOCK_D1    = 16'h00AA;
	localparam logic [DATA_W-1:0] UNLOCK_D2    = 16'h0055;
	localparam logic [DATA_W-1:0] ID_CODE      = 16'h0090;
	localparam logic [DATA_W-1:0] SETUP_CODE   = 16'h0080;
	localparam logic [DATA_W-1:0] CHIP_CODE    = 16'h0010;
	localparam logic [DATA_W-1:0] PROT_CODE    = 16'h0020;
	localparam logic [ADDR_W-1:0] UNLOCK_A     = 18'h0_0555;
	localparam logic [ADDR_W-1:0] UNLOCK_B     = 18'h0_02AA;
	localparam logic [ADDR_W-1:0] ID_MANUF_A   = 18'h0_0000;
	localparam logic [ADDR_W-1:0] ID_DEVICE_A  = 18'h0_0001;

	// data status bits during an erase
	localparam int POLL_BIT    = 7;
	localparam int TOGGLE_BIT  = 6;
	localparam int TIMEOUT_BIT = 5;

	// step counts of each sequence
	localparam logic [3:0] LEN_SINGLE  = 4'h1;
	localparam logic [3:0] LEN_ID      = 4'h5;
	localparam logic [3:0] LEN_ERASE   = 4'h6;
	localparam logic [3:0] LEN_PROTECT = 4'h8;

endpackage

// File: core/flash_bus_cycle.sv
// one asynchronous flash bus cycle, read or write, timed in system clocks
// assumes the caller pulses start only while busy is low
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle (
	input  wire logic                              clk,
	input  wire logic                              rst,
	input  wire logic                              start,
	input  wire logic                              wr,
	input  wire logic [flash_host_pkg::ADDR_W-1:0] addr,
	input  wire logic [flash_host_pkg::DATA_W-1:0] wdata,
	input  wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
	output logic                                   busy,
	output logic                                   done,
	output logic [flash_host_pkg::DATA_W-1:0]      rdata,
	output logic                                   ce_n,
	output logic                                   oe_n,
	output logic                                   we_n,
	output logic [flash_host_pkg::ADDR_W-1:0]      fl_addr,
	output logic [flash_host_pkg::DATA_W-1:0]      dq_o,
	output logic                                   dq_oe
);
	import flash_host_pkg::*;

	typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD} phase_e;

	phase_e     phase_r;
	logic [3:0] cnt_r;
	logic       wr_r;

	assign busy = (phase_r != P_IDLE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_r <= P_IDLE;
			cnt_r   <= 4'h0;
			wr_r    <= 1'b0;
			done    <= 1'b0;
			rdata   <= DATA_RST;
			ce_n    <= 1'b1;
			oe_n    <= 1'b1;
			we_n    <= 1'b1;
			fl_addr <= ADDR_RST;
			dq_o    <= DATA_RST;
			dq_oe   <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (phase_r)
				P_IDLE: begin
					if (start) begin
						wr_r    <= wr;
						ce_n    <= 1'b0;
						fl_addr <= addr;
						dq_o    <= wdata;
						dq_oe   <= wr;
						cnt_r   <= SETUP_CYC - 4'h1;
						phase_r <= P_SETUP;
					end
				end
				P_SETUP: begin
					if (cnt_r == 4'h0) begin
						// device latches the address on this falling strobe
						we_n    <= ~wr_r;
						oe_n    <= wr_r;
						cnt_r   <= (wr_r ? WE_CYC : READ_CYC) - 4'h1;
						phase_r <= P_STROBE;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				P_STROBE: begin
					if (cnt_r == 4'h0) begin
						// write strobe rises before chip select, so data is taken here
						we_n    <= 1'b1;
						oe_n    <= 1'b1;
						if (!wr_r) begin
							rdata <= dq_i;
						end
						cnt_r   <= RECOVER_CYC - 4'h1;
						phase_r <= P_HOLD;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				P_HOLD: begin
					if (cnt_r == 4'h0) begin
						// chip select rises last; an erase starts on this edge
						ce_n    <= 1'b1;
						dq_oe   <= 1'b0;
						done    <= 1'b1;
						phase_r <= P_IDLE;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: core/flash_host_ctrl.sv
// apb-controlled host that drives a parallel nor flash through its pins
// assumes word-mode flash, pins synchronous to CLK_SYS, an external 12 V switch on FL_HV_ID_EN
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl (
	input  wire logic                              CLK_SYS,
	input  wire logic                              RESET,
	input  wire logic                              PSEL,
	input  wire logic                              PENABLE,
	input  wire logic                              PWRITE,
	input  wire logic [7:0]                        PADDR,
	input  wire logic [31:0]                       PWDATA,
	output logic [31:0]                            PRDATA,
	output logic                                   PREADY,
	output logic                                   PSLVERR,
	output logic                                   FL_CE_N,
	output logic                                   FL_OE_N,
	output logic                                   FL_WE_N,
	output logic [flash_host_pkg::ADDR_W-1:0]      FL_ADDR,
	output logic [flash_host_pkg::DATA_W-1:0]      FL_DQ_O,
	output logic                                   FL_DQ_OE,
	input  wire logic [flash_host_pkg::DATA_W-1:0] FL_DQ_I,
	output logic                                   FL_HV_ID_EN
);
	import flash_host_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_STEP, S_WAIT, S_POLL, S_POLL_WAIT, S_ABORT,
		S_ABORT_WAIT} state_e;

	state_e            state_r;
	logic [2:0]        cmd_r;
	logic [3:0]        step_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] wdata_r;
	logic              prot_sel_r;
	logic              done_r;
	logic              ok_r;
	logic              fail_r;
	logic              refused_r;
	logic [DATA_W-1:0] rd_lo_r;
	logic [DATA_W-1:0] rd_hi_r;
	logic              prev_tog_r;
	logic              have_prev_r;
	logic              cyc_start_r;
	logic              cyc_wr_r;
	logic [ADDR_W-1:0] cyc_addr_r;
	logic [DATA_W-1:0] cyc_data_r;
	logic              cyc_busy;
	logic              cyc_done;
	logic [DATA_W-1:0] cyc_rdata;
	logic              acc;
	logic              wr_ctrl;
	logic              go;
	logic              finish;
	logic [34:0]       op;

	// number of bus cycles in each command
	function automatic logic [3:0] seq_len(input logic [2:0] cmd);
		unique case (cmd)
			CMD_ID:         seq_len = LEN_ID;
			CMD_CHIP_ERASE: seq_len = LEN_ERASE;
			CMD_PROTECT:    seq_len = LEN_PROTECT;
			default:        seq_len = LEN_SINGLE;
		endcase
	endfunction

	// {write, address, data} of one step of a command
	function automatic logic [34:0] step_op(input logic [2:0] cmd, input logic [3:0] step,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic psel);
		logic [DATA_W-1:0] c1;
		logic [DATA_W-1:0] c2;
		c1 = (cmd == CMD_ID) ? ID_CODE : SETUP_CODE;
		c2 = (cmd == CMD_CHIP_ERASE) ? CHIP_CODE : PROT_CODE;
		unique case (step)
			4'h0: step_op = {1'b1, UNLOCK_A, UNLOCK_D1};
			4'h1: step_op = {1'b1, UNLOCK_B, UNLOCK_D2};
			4'h2: step_op = {1'b1, UNLOCK_A, c1};
			4'h3: step_op = (cmd == CMD_ID) ? {1'b0, ID_MANUF_A, DATA_RST}
				: {1'b1, UNLOCK_A, UNLOCK_D1};
			4'h4: step_op = (cmd == CMD_ID) ? {1'b0, ID_DEVICE_A, DATA_RST}
				: {1'b1, UNLOCK_B, UNLOCK_D2};
			4'h5: step_op = {1'b1, UNLOCK_A, c2};
			// sense pin at logic high, select bit picks protect or unprotect
			4'h6: step_op = {1'b1, a[17:12], 2'b00, 1'b1, 2'b00, psel, 6'h00, DATA_RST};
			// verify comes straight after the protect write, A1 high
			4'h7: step_op = {1'b0, a[17:12], 2'b00, 1'b1, 7'h00, 1'b1, 1'b0, DATA_RST};
			default: step_op = {1'b0, a, DATA_RST};
		endcase
		if (seq_len(cmd) == LEN_SINGLE) begin
			unique case (cmd)
				// any single cycle may be sent; a stray one only resets the flash decoder
				CMD_WRITE: step_op = {1'b1, a, d};
				CMD_RESET: step_op = {1'b1, a, RESET_CODE};
				default:   step_op = {1'b0, a, DATA_RST};
			endcase
		end
	endfunction

	assign acc     = PSEL & PENABLE & PREADY;
	assign wr_ctrl = acc & PWRITE & (PADDR == REG_CTRL);
	assign go      = wr_ctrl & PWDATA[CTRL_GO_BIT] & (state_r == S_IDLE);
	assign finish  = (state_r == S_ABORT_WAIT && cyc_done)
		|| (state_r == S_WAIT && cyc_done && step_r == seq_len(cmd_r) - 4'h1
			&& cmd_r != CMD_CHIP_ERASE)
		|| (state_r == S_POLL_WAIT && cyc_done && have_prev_r
			&& cyc_rdata[POLL_BIT] && cyc_rdata[TOGGLE_BIT] == prev_tog_r);
	assign op      = step_op(cmd_r, step_r, addr_r, wdata_r, prot_sel_r);

	// apb slave: one wait state, every access answered on the second access cycle
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			PREADY  <= 1'b0;
			PRDATA  <= WORD_ZERO;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL & PENABLE & ~PREADY;
			PSLVERR <= 1'b0;
			if (PSEL & PENABLE & ~PREADY) begin
				PRDATA <= WORD_ZERO;
				unique case (PADDR)
					REG_CTRL: PRDATA <= {14'h0000, prot_sel_r, FL_HV_ID_EN, 13'h0000, cmd_r};
					REG_ADDR:   PRDATA <= {14'h0000, addr_r};
					REG_WDATA:  PRDATA <= {16'h0000, wdata_r};
					REG_STATUS: PRDATA <= {27'h000_0000, refused_r, fail_r, ok_r, done_r,
						(state_r != S_IDLE)};
					REG_RDATA:  PRDATA <= {rd_hi_r, rd_lo_r};
					default:    PSLVERR <= 1'b1;
				endcase
			end
		end
	end

	// software-written configuration
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			cmd_r       <= CMD_READ;
			addr_r      <= ADDR_RST;
			wdata_r     <= DATA_RST;
			prot_sel_r  <= 1'b0;
			FL_HV_ID_EN <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				// identifier voltage on the sense pin reads codes with no command
				FL_HV_ID_EN <= PWDATA[CTRL_HV_BIT];
				prot_sel_r  <= PWDATA[CTRL_PSEL_BIT];
			end
			if (go) begin
				cmd_r <= PWDATA[CTRL_CMD_LSB +: 3];
			end
			// address and data are frozen while a command runs
			if (acc & PWRITE & (PADDR == REG_ADDR) & (state_r == S_IDLE)) begin
				addr_r <= PWDATA[ADDR_W-1:0];
			end
			if (acc & PWRITE & (PADDR == REG_WDATA) & (state_r == S_IDLE)) begin
				wdata_r <= PWDATA[DATA_W-1:0];
			end
		end
	end

	// sticky status; a finish always wins over the clear by go
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			done_r    <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			done_r    <= finish ? 1'b1 : (go ? 1'b0 : done_r);
			refused_r <= (wr_ctrl & PWDATA[CTRL_GO_BIT] & (state_r != S_IDLE)) ? 1'b1
				: (go ? 1'b0 : refused_r);
		end
	end

	// command sequencer
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			state_r     <= S_IDLE;
			step_r      <= 4'h0;
			ok_r        <= 1'b0;
			fail_r      <= 1'b0;
			rd_lo_r     <= DATA_RST;
			rd_hi_r     <= DATA_RST;
			prev_tog_r  <= 1'b0;
			have_prev_r <= 1'b0;
			cyc_start_r <= 1'b0;
			cyc_wr_r    <= 1'b0;
			cyc_addr_r  <= ADDR_RST;
			cyc_data_r  <= DATA_RST;
		end else begin
			cyc_start_r <= 1'b0;
			unique case (state_r)
				S_IDLE: begin
					if (go) begin
						step_r      <= 4'h0;
						ok_r        <= 1'b0;
						fail_r      <= 1'b0;
						have_prev_r <= 1'b0;
						state_r     <= S_STEP;
					end
				end
				S_STEP: begin
					if (!cyc_busy) begin
						{cyc_wr_r, cyc_addr_r, cyc_data_r} <= op;
						cyc_start_r <= 1'b1;
						state_r     <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (cyc_done) begin
						if (!cyc_wr_r) begin
							if (cmd_r == CMD_ID && step_r == LEN_ID - 4'h1) begin
								rd_hi_r <= cyc_rdata;
							end else begin
								rd_lo_r <= cyc_rdata;
							end
						end
						if (step_r != seq_len(cmd_r) - 4'h1) begin
							step_r  <= step_r + 4'h1;
							state_r <= S_STEP;
						end else if (cmd_r == CMD_CHIP_ERASE) begin
							// flash pre-programs and erases on its own; polling follows, then a reset write if it times out
							state_r <= S_POLL;
						end else begin
							state_r <= S_IDLE;
						end
					end
				end
				S_POLL: begin
					if (!cyc_busy) begin
						{cyc_wr_r, cyc_addr_r, cyc_data_r} <= {1'b0, addr_r, DATA_RST};
						cyc_start_r <= 1'b1;
						state_r     <= S_POLL_WAIT;
					end
				end
				S_POLL_WAIT: begin
					if (cyc_done) begin
						rd_lo_r     <= cyc_rdata;
						prev_tog_r  <= cyc_rdata[TOGGLE_BIT];
						have_prev_r <= 1'b1;
						if (finish) begin
							ok_r    <= 1'b1;
							state_r <= S_IDLE;
						end else if (cyc_rdata[TIMEOUT_BIT] && !cyc_rdata[POLL_BIT]) begin
							fail_r  <= 1'b1;
							state_r <= S_ABORT;
						end else begin
							state_r <= S_POLL;
						end
					end
				end
				S_ABORT: begin
					if (!cyc_busy) begin
						// failed erase must be cleared with the reset code
						{cyc_wr_r, cyc_addr_r, cyc_data_r} <= {1'b1, UNLOCK_A, RESET_CODE};
						cyc_start_r <= 1'b1;
						state_r     <= S_ABORT_WAIT;
					end
				end
				S_ABORT_WAIT: begin
					if (cyc_done) begin
						state_r <= S_IDLE;
					end
				end
			endcase
		end
	end

	flash_bus_cycle u_cycle (
		.clk     (CLK_SYS),
		.rst     (RESET),
		.start   (cyc_start_r),
		.wr      (cyc_wr_r),
		.addr    (cyc_addr_r),
		.wdata   (cyc_data_r),
		.dq_i    (FL_DQ_I),
		.busy    (cyc_busy),
		.done    (cyc_done),
		.rdata   (cyc_rdata),
		.ce_n    (FL_CE_N),
		.oe_n    (FL_OE_N),
		.we_n    (FL_WE_N),
		.fl_addr (FL_ADDR),
		.dq_o    (FL_DQ_O),
		.dq_oe   (FL_DQ_OE)
	);
endmodule
`default_nettype wire

// File: tb/flash_host_ctrl_asserts.sv
// pin and bus timing checker for the flash host controller
// assumes it is bound to flash_host_ctrl and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl_asserts (
	input wire logic                              CLK_SYS,
	input wire logic                              RESET,
	input wire logic                              PSEL,
	input wire logic                              PENABLE,
	input wire logic                              PREADY,
	input wire logic                              PSLVERR,
	input wire logic                              FL_CE_N,
	input wire logic                              FL_OE_N,
	input wire logic                              FL_WE_N,
	input wire logic [flash_host_pkg::ADDR_W-1:0] FL_ADDR,
	input wire logic [flash_host_pkg::DATA_W-1:0] FL_DQ_O,
	input wire logic                              FL_DQ_OE
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	a_ce_setup: assert property ($fell(FL_CE_N) |-> (FL_WE_N && FL_OE_N)[*2])
		else $error("strobe inside chip select setup");
	a_we_width: assert property ($fell(FL_WE_N) |-> !FL_WE_N[*5] ##1 FL_WE_N)
		else $error("write strobe width wrong");
	a_oe_width: assert property ($fell(FL_OE_N) |-> ##11 !FL_OE_N ##1 FL_OE_N)
		else $error("read strobe width wrong");
	a_no_clash: assert property (FL_WE_N || FL_OE_N)
		else $error("both strobes low");
	a_strobe_ce: assert property (!FL_WE_N || !FL_OE_N |-> !FL_CE_N)
		else $error("strobe without chip select");
	a_we_drives: assert property (!FL_WE_N |-> FL_DQ_OE && FL_OE_N)
		else $error("write without data drive");
	a_addr_hold: assert property (!FL_CE_N && !$past(FL_CE_N) |->
		$stable(FL_ADDR) && $stable(FL_DQ_O))
		else $error("address or data moved in cycle");
	a_ce_last: assert property ($rose(FL_WE_N) |-> !FL_CE_N[*3] ##1 FL_CE_N)
		else $error("chip select not the later rising");
	a_ce_gap: assert property ($rose(FL_CE_N) |=> FL_CE_N)
		else $error("chip select gap too short");
	a_ready_two: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
		else $error("access phase not two cycles");
	a_err_ready: assert property (PSLVERR |-> PREADY && PSEL)
		else $error("error without ready");
endmodule

bind flash_host_ctrl flash_host_ctrl_asserts u_chk (
	.CLK_SYS (CLK_SYS),
	.RESET   (RESET),
	.PSEL    (PSEL),
	.PENABLE (PENABLE),
	.PREADY  (PREADY),
	.PSLVERR (PSLVERR),
	.FL_CE_N (FL_CE_N),
	.FL_OE_N (FL_OE_N),
	.FL_WE_N (FL_WE_N),
	.FL_ADDR (FL_ADDR),
	.FL_DQ_O (FL_DQ_O),
	.FL_DQ_OE(FL_DQ_OE)
);
`default_nettype wire

// File: tb/flash_dev_model.sv
// behavioural word-mode nor flash: command decoder, id, erase status, protect
// assumes strobes from a host; erase length is counted in status reads
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
	parameter logic [15:0] MANUF_CODE = 16'h0011, // arbitrary
	parameter logic [15:0] DEV_CODE   = 16'h4455, // arbitrary
	parameter int          POLLS      = 4
) (
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [17:0] addr,
	input  wire logic [15:0] din,
	input  wire logic        hv_id,
	input  wire logic        fail_mode,
	output logic      [15:0] dout
);
	logic [15:0] mem [0:15];
	logic [3:0]  prot = 4'h0;
	logic [17:0] addr_l;
	logic [15:0] last = 16'h0000;
	logic [15:0] val;
	logic        id_mode = 1'b0, erase_go = 1'b0, busy = 1'b0, tgl = 1'b0;
	logic        prot_arm = 1'b0, prot_vfy = 1'b0;
	int          step = 0, polls = 0, i;

	task automatic fill(input logic [15:0] v);
		for (int k = 0; k < 16; k++) mem[k] = v;
	endtask
	initial for (i = 0; i < 16; i++) mem[i] = 16'(i) * 16'h1111;

	// only the low field of unlock addresses counts
	function automatic logic unlock_ok(int n, logic [17:0] a, logic [15:0] d);
		if (n % 3 == 0) return a[10:0] == 11'h555 && d[7:0] == 8'hAA;
		return a[10:0] == 11'h2AA && d[7:0] == 8'h55;
	endfunction

	always @(negedge we_n) addr_l = addr;
	always @(posedge we_n) begin
		if (!ce_n && busy) begin
			if (fail_mode && din[7:0] == 8'hF0) busy = 1'b0;
		end else if (!ce_n) begin
			prot_vfy = 1'b0;
			if (din[7:0] == 8'hF0) begin
				step = 0;
				id_mode = 1'b0;
				prot_arm = 1'b0;
			end else if (prot_arm && addr_l[9]) begin
				prot[addr_l[13:12]] = !addr_l[6];
				prot_arm = 1'b0;
				prot_vfy = 1'b1;
			end else if (step == 2 && din[7:0] == 8'h90) begin
				id_mode = 1'b1;
				step = 0;
			end else if (step == 2 && din[7:0] == 8'h80) step = 3;
			else if (step == 5 && din[7:0] == 8'h10) begin
				erase_go = 1'b1;
				step = 0;
			end else if (step == 5 && din[7:0] == 8'h20) begin
				prot_arm = 1'b1;
				step = 0;
			end else if (step != 2 && step != 5 && unlock_ok(step, addr_l, din)) step++;
			else begin
				step = 0;
				id_mode = 1'b0;
			end
		end
	end

	always @(posedge ce_n) if (erase_go) begin
		erase_go = 1'b0;
		busy = 1'b1;
		polls = 0;
		fill(16'h0000);
	end

	always @(posedge oe_n) if (!ce_n) begin
		last = val;
		prot_vfy = 1'b0;
		if (busy) begin
			tgl = !tgl;
			if (!fail_mode) polls++;
			if (polls == POLLS) begin
				busy = 1'b0;
				fill(16'hFFFF);
			end
		end
	end

	always @* begin
		if (busy) val = {8'h00, 1'b0, tgl, fail_mode, 5'h00};
		else if (hv_id || id_mode) val = addr[0] ? DEV_CODE : MANUF_CODE;
		else if (prot_vfy && addr[1]) val = {15'h0000, prot[addr[13:12]]};
		else val = mem[addr[3:0]];
		// no pull on dq: a released bus shows the inverse of the last word
		dout = (!ce_n && !oe_n) ? val : ~last;
	end
endmodule
`default_nettype wire

// File: tb/test_flash_host_ctrl.sv
// self-checking bench: apb master, flash model, one task per scenario
// assumes the package offsets and command codes of flash_host_pkg
`timescale 1ns/10ps
`default_nettype none
module test_flash_host_ctrl;
	import flash_host_pkg::*;
	localparam logic [15:0] MANUF = 16'h0011; // arbitrary
	localparam logic [15:0] DEVC  = 16'h4455; // arbitrary
	localparam int          LIMIT = 60000;
	logic              CLK_SYS, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [7:0]        PADDR;
	logic [31:0]       PWDATA, PRDATA;
	logic              FL_CE_N, FL_OE_N, FL_WE_N, FL_DQ_OE, FL_HV_ID_EN, fail_mode;
	logic [ADDR_W-1:0] FL_ADDR;
	logic [DATA_W-1:0] FL_DQ_O, FL_DQ_I;
	int                fails = 0, checked = 0, cycles = 0;

	flash_host_ctrl u_dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
		.FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE), .FL_DQ_I(FL_DQ_I),
		.FL_HV_ID_EN(FL_HV_ID_EN));
	flash_dev_model #(.MANUF_CODE(MANUF), .DEV_CODE(DEVC)) u_dev (.ce_n(FL_CE_N),
		.oe_n(FL_OE_N), .we_n(FL_WE_N), .addr(FL_ADDR), .din(FL_DQ_O),
		.hv_id(FL_HV_ID_EN), .fail_mode(fail_mode), .dout(FL_DQ_I));

	initial begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end

	task automatic wrap_up();
		if (fails == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge CLK_SYS) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do @(posedge CLK_SYS); while (PREADY !== 1'b1);
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK_SYS);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, WORD_ZERO, q, e);
	endtask
	task automatic go(input logic [2:0] c, input logic sel, input logic hv);
		wr(REG_CTRL, {14'h0000, sel, hv, 7'h00, 1'b1, 5'h00, c});
	endtask
	task automatic wait_done();
		logic [31:0] s;
		do rd(REG_STATUS, s); while (s[ST_DONE_BIT] !== 1'b1);
	endtask
	task automatic run(input logic [2:0] c, input logic [17:0] a, input logic [15:0] d,
		input logic sel, input logic hv);
		wr(REG_ADDR, {14'h0000, a});
		wr(REG_WDATA, {16'h0000, d});
		go(c, sel, hv);
		wait_done();
	endtask
	task automatic rd_lo(input logic [15:0] exp);
		logic [31:0] q;
		rd(REG_RDATA, q);
		chk(32'(q[15:0]), 32'(exp));
	endtask

	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		rd(REG_CTRL, q);
		chk(q, WORD_ZERO);
		rd(REG_STATUS, q);
		chk(q, WORD_ZERO);
		apb(1'b0, 8'h20, WORD_ZERO, q, e);
		chk({q[30:0], e}, 32'h0000_0001);
		chk({30'h0000_0000, FL_CE_N, FL_DQ_OE}, 32'h0000_0002);
	endtask
	task automatic t_read_abort();
		run(CMD_READ, 18'h0_0003, DATA_RST, 1'b0, 1'b0);
		rd_lo(16'h3333);
		run(CMD_WRITE, UNLOCK_A, UNLOCK_D1, 1'b0, 1'b0);
		run(CMD_WRITE, UNLOCK_B, UNLOCK_D2, 1'b0, 1'b0);
		run(CMD_WRITE, UNLOCK_A, 16'h0033, 1'b0, 1'b0);
		run(CMD_WRITE, ADDR_RST, 16'h00B0, 1'b0, 1'b0);
		run(CMD_READ, 18'h0_0002, DATA_RST, 1'b0, 1'b0);
		rd_lo(16'h2222);
	endtask
	task automatic t_id();
		logic [31:0] q;
		run(CMD_ID, ADDR_RST, DATA_RST, 1'b0, 1'b0);
		rd(REG_RDATA, q);
		chk(q, {DEVC, MANUF});
		run(CMD_RESET, ADDR_RST, DATA_RST, 1'b0, 1'b0);
		run(CMD_READ, 18'h0_0001, DATA_RST, 1'b0, 1'b0);
		rd_lo(16'h1111);
		run(CMD_READ, ID_MANUF_A, DATA_RST, 1'b0, 1'b1);
		rd_lo(MANUF);
		run(CMD_READ, ID_DEVICE_A, DATA_RST, 1'b0, 1'b1);
		rd_lo(DEVC);
	endtask
	task automatic t_erase();
		logic [31:0] q;
		wr(REG_ADDR, WORD_ZERO);
		go(CMD_CHIP_ERASE, 1'b0, 1'b0);
		go(CMD_READ, 1'b0, 1'b0);
		rd(REG_STATUS, q);
		chk(32'(q[ST_BUSY_BIT]), 32'h0000_0001);
		wait_done();
		rd(REG_STATUS, q);
		chk(32'(q[4:1]), 32'h0000_000B);
		rd(REG_RDATA, q);
		chk(32'(q[POLL_BIT]), 32'h0000_0001);
		rd(REG_CTRL, q);
		chk(32'(q[2:0]), 32'(CMD_CHIP_ERASE));
		run(CMD_READ, 18'h0_0005, DATA_RST, 1'b0, 1'b0);
		rd_lo(16'hFFFF);
	endtask
	task automatic t_fail();
		logic [31:0] q;
		fail_mode <= 1'b1;
		run(CMD_CHIP_ERASE, ADDR_RST, DATA_RST, 1'b0, 1'b0);
		rd(REG_STATUS, q);
		chk(32'(q[3:2]), 32'h0000_0002);
		fail_mode <= 1'b0;
		run(CMD_READ, 18'h0_0004, DATA_RST, 1'b0, 1'b0);
		rd_lo(16'h0000);
	endtask
	task automatic t_protect();
		run(CMD_PROTECT, 18'h0_2000, DATA_RST, 1'b0, 1'b0);
		rd_lo(16'h0001);
		run(CMD_PROTECT, 18'h0_2000, DATA_RST, 1'b1, 1'b0);
		rd_lo(16'h0000);
	endtask

	initial begin
		RESET = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = WORD_ZERO;
		fail_mode = 1'b0;
		repeat (12) @(posedge CLK_SYS);
		RESET <= 1'b0;
		@(posedge CLK_SYS);
		t_reset();
		t_read_abort();
		t_id();
		t_erase();
		t_fail();
		t_protect();
		wrap_up();
	end
endmodule
`default_nettype wire
